// >>> src/ebac_dev.sv
// Purpose: nv byte memory with its address, data, control and spare io registers
// Assumes: i_por_n is released only with good supply; i_reset_n is the core reset
// Notes: the programming engine lives on i_por_n so it survives a core reset
// How it works
// - byte-addressable nv space, 128/256/512 bytes
// - read strobe stalls core four cycles
// - program start stalls core two cycles
// - mode 00 armed start: erase then write
// - busy bit holds until programming ends
// - no other nv operation while busy
// - mode 01 armed start erases only
// - mode 10 armed start writes without erase
// - software erases before write-only programming
// - programming time from calibrated oscillator
// - busy and done flag show completion
// - core reset does not abort programming
// - software arms before every start
// - io map plus 0x20 in data space
// - bit ops below 0x20 touch one bit
// - status flag cleared by writing one
// - software writes reserved bits as zero
// - three side-effect-free spare registers
// - write arm clears four cycles later
// - mode writes ignored while busy
// - read strobe loads data register at once
// - ready interrupt level while not busy
module ebac_dev #(
   parameter int DEPTH = 512,
   parameter int LONG_TICKS = ebac_pkg::ATOMIC_TICKS,
   parameter int SHORT_TICKS = ebac_pkg::SPLIT_TICKS
) (
   // clock and resets
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_por_n,
   // oscillator
   input wire logic i_cal_osc,
   // io bus
   ebac_if.dev bus
);
   localparam logic [8:0] AMASK = 9'(DEPTH - 1);

   // ----------------------------------------
   // storage
   // ----------------------------------------
   // one byte per address
   logic [7:0] mem [DEPTH];
   logic [7:0] data_r, rdata_r, gp0_r, gp1_r, gp2_r;
   logic [8:0] adr_r, eng_adr_r;
   logic [7:0] eng_data_r;
   logic [1:0] mode_r, eng_mode_r, arm_cnt_r;
   logic [2:0] stall_cnt_r, stall_nxt;
   logic arm_r, busy_r, irq_en_r, done_flag_r, stall_r, irq_r;
   logic rst_s1_r, rst_s2_r, prog_done;

   // ----------------------------------------
   // decode
   // ----------------------------------------
   logic [6:0] ds_a;
   logic [5:0] io_a;
   logic hit, wr, bit_op, start_w, rd_w;
   logic [7:0] nb, on, cur;

   always_comb begin
      ds_a = bus.addr - ebac_pkg::DS_OFS;
      bit_op = (bus.op == ebac_pkg::OP_SBI) || (bus.op == ebac_pkg::OP_BIT_CLEAR);
      if (bus.is_ds) begin
         io_a = ds_a[5:0];
         hit = (bus.addr >= ebac_pkg::DS_OFS) && (bus.addr <= ebac_pkg::DS_TOP) && !bit_op;
      end else begin
         io_a = bus.addr[5:0];
         hit = bit_op ? (bus.addr < ebac_pkg::BIT_LIM) : (bus.addr <= ebac_pkg::IO_TOP);
      end
      if (bus.op == ebac_pkg::OP_NONE) begin
         hit = 1'b0;
      end
      wr = hit && (bus.op != ebac_pkg::OP_IN);
      case (io_a)
         ebac_pkg::A_CTRL: cur = {2'b00, mode_r, irq_en_r, arm_r, busy_r, 1'b0};
         ebac_pkg::A_DATA: cur = data_r;
         ebac_pkg::A_ADRL: cur = adr_r[7:0];
         ebac_pkg::A_ADRH: cur = {7'h00, adr_r[8]};
         ebac_pkg::A_STAT: cur = {7'h00, done_flag_r};
         ebac_pkg::A_GP0: cur = gp0_r;
         ebac_pkg::A_GP1: cur = gp1_r;
         ebac_pkg::A_GP2: cur = gp2_r;
         default: cur = 8'h00;
      endcase
      nb = ebac_pkg::new_byte(bus.op, cur, bus.wdata, bus.bit_idx);
      on = ebac_pkg::ones(bus.op, bus.wdata, bus.bit_idx);
      start_w = wr && (io_a == ebac_pkg::A_CTRL) && on[ebac_pkg::C_BUSY] && arm_r
                && !busy_r && (mode_r != ebac_pkg::MODE_RSVD);
      rd_w = wr && (io_a == ebac_pkg::A_CTRL) && on[ebac_pkg::C_RD] && !busy_r;
      if (rd_w) begin
         stall_nxt = ebac_pkg::RD_STALL;
      end else if (start_w) begin
         stall_nxt = ebac_pkg::PG_STALL;
      end else if (stall_cnt_r != 3'h0) begin
         stall_nxt = stall_cnt_r - 3'h1;
      end else begin
         stall_nxt = 3'h0;
      end
   end

   // ----------------------------------------
   // core-reset registers
   // ----------------------------------------
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         data_r <= ebac_pkg::RST_BYTE;
         adr_r <= 9'h000;
      end else if (rd_w) begin
         data_r <= mem[adr_r];
      end else if (wr && !busy_r) begin
         // address and data frozen while busy
         if (io_a == ebac_pkg::A_DATA) begin
            data_r <= nb;
         end
         if (io_a == ebac_pkg::A_ADRL) begin
            adr_r <= {adr_r[8], nb} & AMASK;
         end
         if (io_a == ebac_pkg::A_ADRH) begin
            adr_r <= {nb[0], adr_r[7:0]} & AMASK;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         gp0_r <= ebac_pkg::RST_BYTE;
         gp1_r <= ebac_pkg::RST_BYTE;
         gp2_r <= ebac_pkg::RST_BYTE;
      end else if (wr) begin
         if (io_a == ebac_pkg::A_GP0) begin
            gp0_r <= nb;
         end
         if (io_a == ebac_pkg::A_GP1) begin
            gp1_r <= nb;
         end
         if (io_a == ebac_pkg::A_GP2) begin
            gp2_r <= nb;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         arm_r <= 1'b0;
         arm_cnt_r <= 2'h0;
         irq_en_r <= 1'b0;
      end else begin
         if (wr && (io_a == ebac_pkg::A_CTRL)) begin
            irq_en_r <= nb[ebac_pkg::C_IRQEN];
         end
         if (wr && (io_a == ebac_pkg::A_CTRL) && on[ebac_pkg::C_ARM] && !start_w) begin
            arm_r <= 1'b1;
            arm_cnt_r <= 2'h0;
         end else if (arm_r) begin
            arm_cnt_r <= arm_cnt_r + 2'h1;
            if (start_w || (arm_cnt_r == ebac_pkg::ARM_LAST)) begin
               arm_r <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         done_flag_r <= 1'b0;
      end else if (prog_done) begin
         done_flag_r <= 1'b1;
      end else if (wr && (io_a == ebac_pkg::A_STAT) && on[0]) begin
         done_flag_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // bus answers
   // ----------------------------------------
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         stall_cnt_r <= 3'h0;
         stall_r <= 1'b0;
         rdata_r <= 8'h00;
         irq_r <= 1'b0;
      end else begin
         stall_cnt_r <= stall_nxt;
         stall_r <= (stall_nxt != 3'h0);
         if (hit && (bus.op == ebac_pkg::OP_IN)) begin
            rdata_r <= cur;
         end
         irq_r <= irq_en_r && !busy_r;
      end
   end

   assign bus.stall = stall_r;
   assign bus.rdata = rdata_r;
   assign bus.ready_irq = irq_r;

   // ----------------------------------------
   // programming engine on power-on reset
   // ----------------------------------------
   always_ff @(posedge i_clk or negedge i_por_n) begin
      if (!i_por_n) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= i_reset_n;
         rst_s2_r <= rst_s1_r;
      end
   end

   always_ff @(posedge i_clk or negedge i_por_n) begin
      if (!i_por_n) begin
         busy_r <= 1'b0;
         mode_r <= ebac_pkg::MODE_ATOMIC;
         eng_mode_r <= ebac_pkg::MODE_ATOMIC;
         eng_adr_r <= 9'h000;
         eng_data_r <= 8'h00;
      end else begin
         if (start_w) begin
            busy_r <= 1'b1;
            eng_mode_r <= mode_r;
            eng_adr_r <= adr_r;
            eng_data_r <= data_r;
         end else if (prog_done) begin
            busy_r <= 1'b0;
         end
         if (!busy_r && !rst_s2_r) begin
            mode_r <= ebac_pkg::MODE_ATOMIC;
         end else if (!busy_r && wr && (io_a == ebac_pkg::A_CTRL)) begin
            mode_r <= nb[ebac_pkg::C_MODE +: 2];
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (prog_done) begin
         case (eng_mode_r)
            ebac_pkg::MODE_ATOMIC: mem[eng_adr_r] <= eng_data_r;
            ebac_pkg::MODE_ERASE: mem[eng_adr_r] <= ebac_pkg::ERASED;
            ebac_pkg::MODE_WRITE: mem[eng_adr_r] <= mem[eng_adr_r] & eng_data_r;
            default: mem[eng_adr_r] <= mem[eng_adr_r];
         endcase
      end
   end

   ebac_prog_timer #(
      .LONG_TICKS(LONG_TICKS),
      .SHORT_TICKS(SHORT_TICKS)
   ) u_timer (
      .i_clk(i_clk),
      .i_por_n(i_por_n),
      .i_cal_osc(i_cal_osc),
      .i_start(start_w),
      .i_long(mode_r == ebac_pkg::MODE_ATOMIC),
      .o_done(prog_done)
   );
endmodule : ebac_dev

// >>> src/ebac_host.sv
// Purpose: core end; turns AHB-Lite commands into single io bus ops
// Assumes: one AHB-Lite master, word transfers, zero wait states
// Notes: a command written while one is pending is dropped
module ebac_host (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // ahb-lite slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   // io bus
   ebac_if.core bus
);
   typedef enum logic [1:0] {
      S_IDLE = 2'b00, S_ISSUE = 2'b01, S_ANSWER = 2'b11, S_WAIT = 2'b10
   } ebac_st_type;
   ebac_st_type st_r;
   logic wph_r;
   logic [31:0] wa_r, cmd_r;
   logic [7:0] rd_r;
   logic [31:0] stat;
   logic launch;

   assign stat = {16'h0000, rd_r, 5'h00, rd_r[cmd_r[22:20]], bus.ready_irq, st_r != S_IDLE};
   assign launch = wph_r && (wa_r == ebac_pkg::H_CMD) && (st_r == S_IDLE);

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wph_r <= 1'b0;
         wa_r <= 32'h0000_0000;
         o_hrdata <= 32'h0000_0000;
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
      end else begin
         wph_r <= i_hsel && i_htrans[1] && i_hready && i_hwrite && (i_hsize == 3'h2);
         wa_r <= i_haddr;
         if (i_hsel && i_htrans[1] && i_hready && !i_hwrite) begin
            o_hrdata <= (i_haddr == ebac_pkg::H_STAT) ? stat :
                        (i_haddr == ebac_pkg::H_CMD) ? cmd_r : 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_r <= S_IDLE;
         cmd_r <= 32'h0000_0000;
         rd_r <= 8'h00;
         bus.op <= ebac_pkg::OP_NONE;
         bus.addr <= 7'h00;
         bus.is_ds <= 1'b0;
         bus.wdata <= 8'h00;
         bus.bit_idx <= 3'h0;
      end else begin
         bus.op <= ebac_pkg::OP_NONE;
         case (st_r)
            S_IDLE: begin
               if (launch) begin
                  cmd_r <= i_hwdata;
                  st_r <= S_ISSUE;
               end
            end
            S_ISSUE: begin
               bus.op <= ebac_pkg::ebac_op_type'(cmd_r[18:16]);
               bus.addr <= cmd_r[14:8];
               bus.is_ds <= cmd_r[19];
               bus.wdata <= cmd_r[7:0];
               bus.bit_idx <= cmd_r[22:20];
               st_r <= S_ANSWER;
            end
            // stall and rdata are registered: valid one edge after the op
            S_ANSWER: begin
               st_r <= S_WAIT;
            end
            S_WAIT: begin
               if (!bus.stall) begin
                  rd_r <= bus.rdata;
                  st_r <= S_IDLE;
               end
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end
endmodule : ebac_host

// >>> src/ebac_if.sv
// Purpose: io bus between the core end and the nv memory end
// Assumes: both ends on one clock
// Notes: op is valid for one cycle; stall answers the cycle after
interface ebac_if;
   ebac_pkg::ebac_op_type op;
   logic [6:0] addr;
   logic is_ds;
   logic [7:0] wdata;
   logic [2:0] bit_idx;
   logic [7:0] rdata;
   logic stall;
   logic ready_irq;
   modport dev (input op, addr, is_ds, wdata, bit_idx, output rdata, stall, ready_irq);
   modport core (output op, addr, is_ds, wdata, bit_idx, input rdata, stall, ready_irq);
endinterface : ebac_if

// >>> src/ebac_pkg.sv
// Purpose: shared constants, types and helpers of the nv byte access block
// Assumes: one 125 MHz core clock; programming timed by a separate oscillator
// Notes: io addresses are 6-bit; data-space addresses are 7-bit
package ebac_pkg;
   // ----------------------------------------
   // io map
   // ----------------------------------------
   localparam logic [5:0] A_CTRL = 6'h1C;
   localparam logic [5:0] A_DATA = 6'h1D;
   localparam logic [5:0] A_ADRL = 6'h1E;
   localparam logic [5:0] A_ADRH = 6'h1F;
   localparam logic [5:0] A_STAT = 6'h1B;
   localparam logic [5:0] A_GP0 = 6'h13;
   localparam logic [5:0] A_GP1 = 6'h14;
   localparam logic [5:0] A_GP2 = 6'h15;
   localparam logic [6:0] DS_OFS = 7'h20;
   localparam logic [6:0] DS_TOP = 7'h5F;
   localparam logic [6:0] IO_TOP = 7'h3F;
   localparam logic [6:0] BIT_LIM = 7'h20;
   // ----------------------------------------
   // control fields and values
   // ----------------------------------------
   localparam int C_RD = 0;
   localparam int C_BUSY = 1;
   localparam int C_ARM = 2;
   localparam int C_IRQEN = 3;
   localparam int C_MODE = 4;
   localparam logic [1:0] MODE_ATOMIC = 2'h0;
   localparam logic [1:0] MODE_ERASE = 2'h1;
   localparam logic [1:0] MODE_WRITE = 2'h2;
   localparam logic [1:0] MODE_RSVD = 2'h3;
   localparam logic [7:0] ERASED = 8'hFF;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [1:0] ARM_LAST = 2'h3;
   localparam logic [2:0] RD_STALL = 3'h4;
   localparam logic [2:0] PG_STALL = 3'h2;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam real ATOMIC_MS = 3.4;
   localparam real SPLIT_MS = 1.8;
   localparam real OSC_KHZ = 8000.0;
   localparam int ATOMIC_TICKS = int'($ceil(ATOMIC_MS * OSC_KHZ));
   localparam int SPLIT_TICKS = int'($ceil(SPLIT_MS * OSC_KHZ));
   // ----------------------------------------
   // host side map
   // ----------------------------------------
   localparam logic [31:0] H_CMD = 32'h0000_0000;
   localparam logic [31:0] H_STAT = 32'h0000_0004;
   typedef enum logic [2:0] {
      OP_NONE = 3'h0, OP_IN = 3'h1, OP_OUT = 3'h2, OP_SBI = 3'h3, OP_BIT_CLEAR = 3'h4
   } ebac_op_type;

   // value a register takes after an op; bit ops touch only the named bit
   function automatic logic [7:0] new_byte(ebac_op_type op, logic [7:0] old,
                                           logic [7:0] wd, logic [2:0] idx);
      logic [7:0] m;
      m = 8'h01 << idx;
      case (op)
         OP_OUT: new_byte = wd;
         OP_SBI: new_byte = old | m;
         OP_BIT_CLEAR: new_byte = old & ~m;
         default: new_byte = old;
      endcase
   endfunction : new_byte

   // bits that an op writes as one (triggers and write-one-to-clear)
   function automatic logic [7:0] ones(ebac_op_type op, logic [7:0] wd, logic [2:0] idx);
      case (op)
         OP_OUT: ones = wd;
         OP_SBI: ones = 8'h01 << idx;
         default: ones = 8'h00;
      endcase
   endfunction : ones
endpackage : ebac_pkg

// >>> src/ebac_prog_timer.sv
// Purpose: self-timed programming duration counted on oscillator edges
// Assumes: i_cal_osc is a free-running level from the trimmed oscillator
// Notes: runs on the power-on reset so a core reset does not cut it short
module ebac_prog_timer #(
   parameter int LONG_TICKS = ebac_pkg::ATOMIC_TICKS,
   parameter int SHORT_TICKS = ebac_pkg::SPLIT_TICKS,
   parameter int CW = 16
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_por_n,
   // oscillator
   input wire logic i_cal_osc,
   // control
   input wire logic i_start,
   input wire logic i_long,
   output logic o_done
);
   logic s1_r, s2_r, s3_r, run_r;
   logic [CW-1:0] cnt_r;

   always_ff @(posedge i_clk or negedge i_por_n) begin
      if (!i_por_n) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end else begin
         s1_r <= i_cal_osc;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   always_ff @(posedge i_clk or negedge i_por_n) begin
      if (!i_por_n) begin
         run_r <= 1'b0;
         cnt_r <= '0;
         o_done <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (i_start) begin
            run_r <= 1'b1;
            cnt_r <= i_long ? CW'(LONG_TICKS - 1) : CW'(SHORT_TICKS - 1);
         end else if (run_r && s2_r && !s3_r) begin
            if (cnt_r == '0) begin
               run_r <= 1'b0;
               o_done <= 1'b1;
            end else begin
               cnt_r <= cnt_r - 1'b1;
            end
         end
      end
   end
endmodule : ebac_prog_timer

// >>> testbench/ebac_properties.sv
// Purpose: timing checks on the io bus between the core end and the nv end
// Assumes: one clock domain, async active-low core reset
// Notes: busy is not on the bus, so the checks lean on stall, rdata and irq
module ebac_properties (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // io bus
   input wire ebac_pkg::ebac_op_type op,
   input wire logic [6:0] addr,
   input wire logic is_ds,
   input wire logic [7:0] wdata,
   input wire logic [2:0] bit_idx,
   input wire logic [7:0] rdata,
   input wire logic stall,
   input wire logic ready_irq
);
   timeunit 1ns;
   timeprecision 100ps;
   logic rd_hit;
   logic pg_hit;
   // a bit set on the control register; a refused one shows no stall
   assign rd_hit = op == ebac_pkg::OP_SBI && !is_ds && addr == 7'h1C && bit_idx == 3'h0;
   assign pg_hit = op == ebac_pkg::OP_SBI && !is_ds && addr == 7'h1C && bit_idx == 3'h1;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);
   read_stall_a: assert property (rd_hit ##1 stall |-> stall [*4] ##1 !stall)
      else $error("read stall length wrong");
   prog_stall_a: assert property (pg_hit ##1 stall |-> stall [*2] ##1 !stall)
      else $error("program stall length wrong");
   stall_bound_a: assert property (stall [*4] |=> !stall)
      else $error("stall longer than four cycles");
   stall_cause_a: assert property ($rose(stall) |->
      $past(op) inside {ebac_pkg::OP_SBI, ebac_pkg::OP_OUT})
      else $error("stall without a triggering op");
   quiet_ops_a: assert property ((op == ebac_pkg::OP_IN || op == ebac_pkg::OP_BIT_CLEAR)
      |=> !stall)
      else $error("stall after in or clear op");
   bitop_range_a: assert property (op == ebac_pkg::OP_SBI && (is_ds || addr >= 7'h20)
      |=> !stall)
      else $error("bit op outside low io range acted");
   out_quiet_a: assert property (op == ebac_pkg::OP_OUT && addr[4:0] != 5'h1C |=> !stall)
      else $error("stall after plain register write");
   rdata_src_a: assert property (!$stable(rdata) |-> $past(op) == ebac_pkg::OP_IN)
      else $error("rdata changed without an in op");
   busy_irq_a: assert property (pg_hit ##1 stall |-> ##[0:2] !ready_irq)
      else $error("ready irq stayed high while busy");
endmodule : ebac_properties

// >>> testbench/eeprom_byte_access_ctrl_test.sv
// Purpose: drives both ends of the nv byte access block through AHB-Lite
// Assumes: short programming counts; oscillator unrelated to the core clock
// Notes: arm and start go back to back, since polling would overrun the arm window
module eeprom_byte_access_ctrl_test;
   timeunit 1ns;
   timeprecision 100ps;
   // ----------
   // signals
   // ----------
   localparam logic [6:0] CTL = {1'b0, ebac_pkg::A_CTRL};
   localparam logic [6:0] DAT = {1'b0, ebac_pkg::A_DATA};
   localparam logic [6:0] ADL = {1'b0, ebac_pkg::A_ADRL};
   localparam logic [6:0] ADH = {1'b0, ebac_pkg::A_ADRH};
   localparam logic [6:0] STA = {1'b0, ebac_pkg::A_STAT};
   localparam logic [2:0] B_RD = 3'(ebac_pkg::C_RD);
   localparam logic [2:0] B_BUSY = 3'(ebac_pkg::C_BUSY);
   localparam logic [2:0] B_ARM = 3'(ebac_pkg::C_ARM);
   logic i_clk = 1'b0;
   logic i_reset_n = 1'b0;
   logic i_por_n = 1'b0;
   logic i_cal_osc = 1'b0;
   logic i_hsel = 1'b0;
   logic [31:0] i_haddr = 32'h0;
   logic [1:0] i_htrans = 2'h0;
   logic i_hwrite = 1'b0;
   logic [31:0] i_hwdata = 32'h0;
   logic [31:0] o_hrdata;
   logic o_hreadyout;
   logic o_hresp;
   int err_count = 0;
   int n_compared = 0;
   ebac_if bus ();
   ebac_host u_ebac_host (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_hsel(i_hsel),
      .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2),
      .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hrdata(o_hrdata),
      .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .bus(bus));
   ebac_dev #(.DEPTH(512), .LONG_TICKS(8), .SHORT_TICKS(4)) u_ebac_dev (.i_clk(i_clk),
      .i_reset_n(i_reset_n), .i_por_n(i_por_n), .i_cal_osc(i_cal_osc), .bus(bus));
   ebac_properties u_ebac_properties (.i_clk(i_clk), .i_reset_n(i_reset_n), .op(bus.op),
      .addr(bus.addr), .is_ds(bus.is_ds), .wdata(bus.wdata), .bit_idx(bus.bit_idx),
      .rdata(bus.rdata), .stall(bus.stall), .ready_irq(bus.ready_irq));
   always #4 i_clk = ~i_clk;
   always #27 i_cal_osc = ~i_cal_osc;
   // ----------
   // helpers
   // ----------
   task automatic end_sim();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim
   task automatic fail();
      err_count++;
      end_sim();
   endtask : fail
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wait_ready();
      int n;
      n = 0;
      @(posedge i_clk);
      while (o_hreadyout !== 1'b1) begin
         n++;
         if (n > 50) fail();
         @(posedge i_clk);
      end
   endtask : wait_ready
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      i_hsel <= 1'b1;
      i_haddr <= a;
      i_hwrite <= wr;
      i_htrans <= 2'h2;
      wait_ready();
      i_htrans <= 2'h0;
      i_hsel <= 1'b0;
      i_hwdata <= wr ? wd : 32'h0;
      wait_ready();
      rd = o_hrdata;
   endtask : ahb
   function automatic logic [31:0] cmd(ebac_pkg::ebac_op_type op, logic [6:0] a,
                                       logic [7:0] wd, logic [2:0] idx, logic ds);
      return {9'h0, idx, ds, op, 1'b0, a, wd};
   endfunction : cmd
   // poll the host until its pending op has gone out
   task automatic settle();
      logic [31:0] st;
      int n;
      for (n = 0; n < 40; n++) begin
         ahb(1'b0, ebac_pkg::H_STAT, 32'h0, st);
         if (st[0] === 1'b0) break;
      end
      if (n == 40) fail();
   endtask : settle
   task automatic io(input ebac_pkg::ebac_op_type op, input logic [6:0] a,
                     input logic [7:0] wd, input logic [2:0] idx, input logic ds);
      logic [31:0] st;
      ahb(1'b1, ebac_pkg::H_CMD, cmd(op, a, wd, idx, ds), st);
      settle();
   endtask : io
   task automatic out(input logic [6:0] a, input logic [7:0] d);
      io(ebac_pkg::OP_OUT, a, d, 3'h0, 1'b0);
   endtask : out
   task automatic bset(input logic [6:0] a, input logic [2:0] i);
      io(ebac_pkg::OP_SBI, a, 8'h00, i, 1'b0);
   endtask : bset
   task automatic rd_io(input logic [6:0] a, output logic [7:0] b);
      logic [31:0] st;
      io(ebac_pkg::OP_IN, a, 8'h00, 3'h0, 1'b0);
      ahb(1'b0, ebac_pkg::H_STAT, 32'h0, st);
      b = st[15:8];
   endtask : rd_io
   task automatic wait_idle();
      logic [7:0] c;
      int n;
      for (n = 0; n < 40; n++) begin
         rd_io(CTL, c);
         if (c[B_BUSY] === 1'b0) break;
      end
      if (n == 40) fail();
   endtask : wait_idle
   // later start writes are dropped by the host or refused as unarmed
   task automatic prog(input logic [7:0] c, input logic [8:0] a, input logic [7:0] d);
      logic [31:0] st;
      out(CTL, c);
      out(ADL, a[7:0]);
      out(ADH, {7'h00, a[8]});
      out(DAT, d);
      ahb(1'b1, ebac_pkg::H_CMD, cmd(ebac_pkg::OP_SBI, CTL, 8'h00, B_ARM, 1'b0), st);
      repeat (3) ahb(1'b1, ebac_pkg::H_CMD, cmd(ebac_pkg::OP_SBI, CTL, 8'h00, B_BUSY, 1'b0), st);
      settle();
   endtask : prog
   task automatic read_nv(input logic [8:0] a, output logic [7:0] b);
      out(ADL, a[7:0]);
      out(ADH, {7'h00, a[8]});
      bset(CTL, B_RD);
      rd_io(DAT, b);
   endtask : read_nv
   // ----------
   // scenarios
   // ----------
   task automatic t_spare();
      logic [7:0] b;
      rd_io({1'b0, ebac_pkg::A_GP2}, b);
      check(b, 8'h00);
      check({7'h00, o_hresp}, 8'h00);
      io(ebac_pkg::OP_OUT, 7'h33, 8'hA5, 3'h0, 1'b1);
      rd_io({1'b0, ebac_pkg::A_GP0}, b);
      check(b, 8'hA5);
      bset({1'b0, ebac_pkg::A_GP0}, 3'h1);
      io(ebac_pkg::OP_BIT_CLEAR, {1'b0, ebac_pkg::A_GP0}, 8'h00, 3'h7, 1'b0);
      io(ebac_pkg::OP_SBI, 7'h33, 8'h00, 3'h3, 1'b1);
      rd_io({1'b0, ebac_pkg::A_GP0}, b);
      check(b, 8'h27);
      $display("test spare done");
   endtask : t_spare
   task automatic t_modes();
      logic [7:0] b;
      prog({2'h0, ebac_pkg::MODE_ERASE, 4'h0}, 9'h105, 8'h00);
      wait_idle();
      read_nv(9'h105, b);
      check(b, ebac_pkg::ERASED);
      prog({2'h0, ebac_pkg::MODE_WRITE, 4'h0}, 9'h105, 8'h5A);
      wait_idle();
      read_nv(9'h105, b);
      check(b, 8'h5A);
      prog({2'h0, ebac_pkg::MODE_ATOMIC, 4'h0}, 9'h005, 8'hC3);
      wait_idle();
      read_nv(9'h005, b);
      check(b, 8'hC3);
      read_nv(9'h105, b);
      check(b, 8'h5A);
      rd_io(STA, b);
      check({7'h00, b[0]}, 8'h01);
      out(STA, 8'h01);
      rd_io(STA, b);
      check({7'h00, b[0]}, 8'h00);
      $display("test modes done");
   endtask : t_modes
   task automatic t_busy();
      logic [7:0] b;
      logic [31:0] st;
      prog(8'h08, 9'h006, 8'h11);
      rd_io(CTL, b);
      check(b & 8'h3E, 8'h0A);
      ahb(1'b0, ebac_pkg::H_STAT, 32'h0, st);
      check({7'h00, st[1]}, 8'h00);
      out(CTL, 8'h28);
      out(ADL, 8'h05);
      bset(CTL, B_RD);
      rd_io(DAT, b);
      check(b, 8'h11);
      wait_idle();
      rd_io(CTL, b);
      check(b & 8'h30, 8'h00);
      ahb(1'b0, ebac_pkg::H_STAT, 32'h0, st);
      check({7'h00, st[1]}, 8'h01);
      read_nv(9'h006, b);
      check(b, 8'h11);
      $display("test busy done");
   endtask : t_busy
   task automatic t_arm();
      logic [7:0] b;
      out(CTL, 8'h00);
      bset(CTL, B_BUSY);
      rd_io(CTL, b);
      check(b & 8'h06, 8'h00);
      bset(CTL, B_ARM);
      bset(CTL, B_BUSY);
      rd_io(CTL, b);
      check(b & 8'h06, 8'h00);
      // reserved mode: an armed start must not begin programming
      prog(8'h30, 9'h009, 8'h77);
      rd_io(CTL, b);
      check(b & 8'h06, 8'h00);
      $display("test arm done");
   endtask : t_arm
   task automatic t_reset();
      logic [7:0] b;
      prog(8'h00, 9'h008, 8'h3C);
      i_reset_n <= 1'b0;
      repeat (3) @(posedge i_clk);
      i_reset_n <= 1'b1;
      @(posedge i_clk);
      rd_io(CTL, b);
      check(b & 8'h02, 8'h02);
      wait_idle();
      read_nv(9'h008, b);
      check(b, 8'h3C);
      $display("test reset done");
   endtask : t_reset
   initial begin
      repeat (5) @(posedge i_clk);
      i_reset_n <= 1'b1;
      i_por_n <= 1'b1;
      @(posedge i_clk);
      t_spare();
      t_modes();
      t_busy();
      t_arm();
      t_reset();
      end_sim();
   end
endmodule : eeprom_byte_access_ctrl_test
